// ---- rtl/fcq_consts.vh ----
// Constants for the feature, cache, queue and coalescing block.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef FCQ_CONSTS_VH
`define FCQ_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define FCQ_OFS_CMD 8'h00
`define FCQ_OFS_PARAM 8'h04
`define FCQ_OFS_RESULT 8'h08
`define FCQ_OFS_STATUS 8'h0C
`define FCQ_OFS_COAL 8'h10

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define FCQ_CMD_GO_BIT 0
`define FCQ_CMD_SET_BIT 1
`define FCQ_CMD_FID_HI 15
`define FCQ_CMD_FID_LO 8

// ----------------------------------------------------------------
// Feature identifiers
// ----------------------------------------------------------------
`define FCQ_FID_VCACHE 8'h06
`define FCQ_FID_QUEUES 8'h07
`define FCQ_FID_COALESCE 8'h08

// ----------------------------------------------------------------
// Parameter dword fields
// ----------------------------------------------------------------
`define FCQ_VCACHE_ON_BIT 0
`define FCQ_CQ_REQ_HI 31
`define FCQ_CQ_REQ_LO 16
`define FCQ_SQ_REQ_HI 15
`define FCQ_SQ_REQ_LO 0
`define FCQ_COAL_TIME_HI 15
`define FCQ_COAL_TIME_LO 8
`define FCQ_COAL_THR_HI 7
`define FCQ_COAL_THR_LO 0
`define FCQ_COUNT_ILLEGAL 16'hFFFF

// ----------------------------------------------------------------
// Completion status codes
// ----------------------------------------------------------------
`define FCQ_ST_OK 2'h0
`define FCQ_ST_BAD_FIELD 2'h1
`define FCQ_ST_BAD_FEATURE 2'h2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FCQ_RST_WORD 32'h0000_0000
`define FCQ_RST_BYTE 8'h00
`define FCQ_COAL_UNIT_NS 100000
`define FCQ_CLK_PERIOD_NS 50

`endif

// ---- rtl/fcq_queue_alloc.v ----
// Queue count allocator for one queue kind (completion or submission).
// Assumes a zero-based request that the caller has already range checked.
`timescale 1ns/100ps

module fcq_queue_alloc #(
  parameter [15:0] MAX_ZB = 16'h003F,
  parameter [15:0] UNIT_MASK = 16'h0003
) (
  req_zb,
  alloc_zb
);
  input wire [15:0] req_zb;
  output reg [15:0] alloc_zb;

  reg [15:0] rounded;

  // Round up to the allocation unit, then clip to what exists
  always @* begin
    rounded = req_zb | UNIT_MASK; // Zero-based OR mask rounds count up
    if (rounded > MAX_ZB) begin
      alloc_zb = MAX_ZB; // Supply may be short of the request
    end else begin
      alloc_zb = rounded;
    end
  end
endmodule // fcq_queue_alloc

// ---- rtl/fcq_coalesce_vec.v ----
// Interrupt aggregation for one interrupt vector.
// Assumes a one-cycle time tick and completion strobes already decoded
// to this vector; fires a one-cycle interrupt request.
`timescale 1ns/100ps

module fcq_coalesce_vec (
  clk_sys,
  rst,
  tick,
  cpl_hit,
  cpl_urgent,
  db_hit,
  coal_time,
  coal_thr,
  irq_reg
);
  input wire clk_sys;
  input wire rst;
  input wire tick;
  input wire cpl_hit;
  input wire cpl_urgent;
  input wire db_hit;
  input wire [7:0] coal_time;
  input wire [7:0] coal_thr;
  output reg irq_reg;
  reg [8:0] cnt_reg;
  reg [8:0] cnt_next;
  reg [7:0] age_reg;
  reg [7:0] age_next;
  reg irq_next;
  reg disabled;

  // Next state of entry count and age
  always @* begin
    disabled = (coal_time == 8'h00) || (coal_thr == 8'h00);
    cnt_next = cnt_reg;
    age_next = age_reg;
    irq_next = 1'b0;
    if (db_hit) begin
      cnt_next = 9'h000; // Host is draining; restart aggregation
      age_next = 8'h00;
    end else if (tick && cnt_reg != 9'h000 && age_reg != 8'hFF) begin
      age_next = age_reg + 8'h01;
    end
    if (cpl_hit) begin
      if (cpl_urgent) begin
        irq_next = 1'b1; // Error or admin completions go out now
      end else begin
        cnt_next = cnt_next + 9'h001;
        if (cnt_next > {1'b0, coal_thr}) begin
          irq_next = 1'b1; // Zero-based minimum reached
        end
      end
    end
    // Time limit, or coalescing off with entries waiting
    if (cnt_next != 9'h000 && (disabled || age_next >= coal_time)) begin
      irq_next = 1'b1;
    end
    if (irq_next) begin
      cnt_next = 9'h000;
      age_next = 8'h00;
    end
  end

  // State registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 9'h000;
      age_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      age_reg <= age_next;
      irq_reg <= irq_next;
    end
  end
endmodule // fcq_coalesce_vec

// ---- rtl/fcq_feature_ctrl.v ----
// Feature command interpreter: volatile write cache, queue count
// negotiation and interrupt coalescing, with per-vector aggregation.
// Assumes software on a plain register port with one-cycle read data,
// and completion and doorbell strobes synchronous to clk_sys.
`timescale 1ns/100ps
`include "fcq_consts.vh"

module fcq_feature_ctrl #(
  parameter HAS_VCACHE = 1,
  parameter CACHE_POWER_SAFE = 0,
  parameter [15:0] MAX_CQ_ZB = 16'h003F,
  parameter [15:0] MAX_SQ_ZB = 16'h003F,
  parameter [15:0] ALLOC_UNIT_MASK = 16'h0000,
  parameter NUM_VEC = 4,
  parameter VEC_W = 2
) (
  clk_sys,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  int_mode,
  cpl_valid,
  cpl_vector,
  cpl_admin,
  cpl_error,
  cqhd_wr,
  cqhd_vector,
  cache_enable,
  irq_req
);

  // ----------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------
  // Clock and asynchronous reset
  input wire clk_sys;
  input wire rst;
  // Register port; read data is registered and lasts one cycle
  input wire [7:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  // Interrupt mode and completion side strobes
  input wire [1:0] int_mode;
  input wire cpl_valid;
  input wire [VEC_W-1:0] cpl_vector;
  input wire cpl_admin;
  input wire cpl_error;
  input wire cqhd_wr;
  input wire [VEC_W-1:0] cqhd_vector;
  // Cache control and per-vector interrupt requests
  output wire cache_enable;
  output wire [NUM_VEC-1:0] irq_req;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  // 100 microsecond unit at the 50 ns clock: 2000 cycles, fits 12 bits
  localparam [31:0] TICK_CYC = `FCQ_COAL_UNIT_NS / `FCQ_CLK_PERIOD_NS;
  localparam [11:0] TICK_LAST = TICK_CYC[11:0] - 12'h001;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Software-visible words
  reg [31:0] param_reg;
  reg [31:0] result_reg;
  reg [1:0] status_reg;
  reg cmd_done_reg;
  // Feature settings and allocation
  reg vcache_on_reg;
  reg alloc_locked_reg;
  reg [15:0] cq_alloc_reg;
  reg [15:0] sq_alloc_reg;
  reg [7:0] coal_time_reg;
  reg [7:0] coal_thr_reg;
  // Interrupt mode history and shared time base
  reg [1:0] int_mode_reg;
  reg [11:0] tick_cnt_reg;
  reg tick_reg;

  // Command decode
  wire cmd_go;
  wire cmd_set;
  wire [7:0] cmd_fid;
  wire [15:0] cq_req;
  wire [15:0] sq_req;
  wire [15:0] cq_alloc_calc;
  wire [15:0] sq_alloc_calc;
  wire req_illegal;
  wire mode_changed;

  // Next values of command results
  reg [31:0] result_next;
  reg [1:0] status_next;
  reg vcache_on_next;
  reg alloc_locked_next;
  reg [15:0] cq_alloc_next;
  reg [15:0] sq_alloc_next;
  reg [7:0] coal_time_next;
  reg [7:0] coal_thr_next;

  // ----------------------------------------------------------------
  // Command decode from the command register write
  // ----------------------------------------------------------------
  // Feature id and set bit come straight off the command write, so the
  // parameter word must already stand when the go bit is written
  assign cmd_go = reg_wr && (reg_addr == `FCQ_OFS_CMD) && reg_wdata[`FCQ_CMD_GO_BIT];
  assign cmd_set = reg_wdata[`FCQ_CMD_SET_BIT];
  assign cmd_fid = reg_wdata[`FCQ_CMD_FID_HI:`FCQ_CMD_FID_LO];
  assign cq_req = param_reg[`FCQ_CQ_REQ_HI:`FCQ_CQ_REQ_LO];
  assign sq_req = param_reg[`FCQ_SQ_REQ_HI:`FCQ_SQ_REQ_LO];
  assign req_illegal = (cq_req == `FCQ_COUNT_ILLEGAL) || (sq_req == `FCQ_COUNT_ILLEGAL);
  assign mode_changed = (int_mode != int_mode_reg);

  // Power-safe cache is not volatile, so the enable bit is moot
  assign cache_enable = (HAS_VCACHE != 0) && (CACHE_POWER_SAFE == 0) && vcache_on_reg;

  // ----------------------------------------------------------------
  // Queue allocation, one allocator per queue kind
  // ----------------------------------------------------------------
  // Allocation is worked out all the time from the standing parameter
  // word; only a set command on an unlocked allocation latches it
  fcq_queue_alloc #(
    .MAX_ZB(MAX_CQ_ZB),
    .UNIT_MASK(ALLOC_UNIT_MASK)
  ) u_cq_alloc (
    .req_zb(cq_req),
    .alloc_zb(cq_alloc_calc)
  );

  fcq_queue_alloc #(
    .MAX_ZB(MAX_SQ_ZB),
    .UNIT_MASK(ALLOC_UNIT_MASK)
  ) u_sq_alloc (
    .req_zb(sq_req),
    .alloc_zb(sq_alloc_calc)
  );

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  // Every command completes in the cycle of its write; no stall needed
  always @* begin
    result_next = result_reg;
    status_next = status_reg;
    vcache_on_next = vcache_on_reg;
    alloc_locked_next = alloc_locked_reg;
    cq_alloc_next = cq_alloc_reg;
    sq_alloc_next = sq_alloc_reg;
    coal_time_next = coal_time_reg;
    coal_thr_next = coal_thr_reg;
    // Mode change goes first, so a set in the same cycle still lands
    if (mode_changed) begin
      coal_time_next = `FCQ_RST_BYTE; // Settings dropped on mode change
      coal_thr_next = `FCQ_RST_BYTE;
    end
    if (cmd_go) begin
      status_next = `FCQ_ST_OK;
      result_next = `FCQ_RST_WORD;
      case (cmd_fid)
        `FCQ_FID_VCACHE: begin
          if (HAS_VCACHE != 0) begin
            if (cmd_set) begin
              vcache_on_next = param_reg[`FCQ_VCACHE_ON_BIT];
            end
            // Only bit 0 is defined; the rest read as zero
            result_next = {31'h0000_0000, cmd_set ? param_reg[`FCQ_VCACHE_ON_BIT] : vcache_on_reg};
          end else begin
            // No cache built in: the feature is unknown here
            status_next = `FCQ_ST_BAD_FEATURE;
          end
        end
        `FCQ_FID_QUEUES: begin
          // All ones asks for more queues than a field can name
          if (cmd_set && req_illegal) begin
            status_next = `FCQ_ST_BAD_FIELD;
            result_next = {cq_alloc_reg, sq_alloc_reg};
          end else if (cmd_set && !alloc_locked_reg) begin
            cq_alloc_next = cq_alloc_calc;
            sq_alloc_next = sq_alloc_calc;
            alloc_locked_next = 1'b1; // Frozen until reset
            result_next = {cq_alloc_calc, sq_alloc_calc};
          end else begin
            // Later sets and all gets see the standing allocation
            result_next = {cq_alloc_reg, sq_alloc_reg};
          end
        end
        `FCQ_FID_COALESCE: begin
          // Reserved upper half is dropped on the way in and out
          if (cmd_set) begin
            coal_time_next = param_reg[`FCQ_COAL_TIME_HI:`FCQ_COAL_TIME_LO];
            coal_thr_next = param_reg[`FCQ_COAL_THR_HI:`FCQ_COAL_THR_LO];
            result_next = {16'h0000, param_reg[15:0]};
          end else begin
            result_next = {16'h0000, coal_time_reg, coal_thr_reg};
          end
        end
        default: begin
          status_next = `FCQ_ST_BAD_FEATURE;
        end
      endcase
    end
  end

  // Command state registers
  // Allocation resets to the full supply, so a get before any set
  // reports the most that could be granted
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_reg <= `FCQ_RST_WORD;
      status_reg <= `FCQ_ST_OK;
      cmd_done_reg <= 1'b0;
      vcache_on_reg <= 1'b0;
      alloc_locked_reg <= 1'b0;
      cq_alloc_reg <= MAX_CQ_ZB;
      sq_alloc_reg <= MAX_SQ_ZB;
      coal_time_reg <= `FCQ_RST_BYTE;
      coal_thr_reg <= `FCQ_RST_BYTE;
    end else begin
      result_reg <= result_next;
      status_reg <= status_next;
      cmd_done_reg <= cmd_done_reg | cmd_go;
      vcache_on_reg <= vcache_on_next;
      alloc_locked_reg <= alloc_locked_next;
      cq_alloc_reg <= cq_alloc_next;
      sq_alloc_reg <= sq_alloc_next;
      coal_time_reg <= coal_time_next;
      coal_thr_reg <= coal_thr_next;
    end
  end

  // ----------------------------------------------------------------
  // Parameter register and interrupt mode tracking
  // ----------------------------------------------------------------
  // Mode history starts from zero, so a nonzero mode after reset
  // looks like a change; settings are zero then anyway
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      param_reg <= `FCQ_RST_WORD;
      int_mode_reg <= 2'h0;
    end else begin
      int_mode_reg <= int_mode;
      // Parameter word holds until software writes it again
      if (reg_wr && reg_addr == `FCQ_OFS_PARAM) begin
        param_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= `FCQ_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        `FCQ_OFS_CMD: reg_rdata <= 32'h0000_0000;
        `FCQ_OFS_PARAM: reg_rdata <= param_reg;
        `FCQ_OFS_RESULT: reg_rdata <= result_reg;
        // Status: [1:0] last code, [2] done, [8] locked, [9] cache
        `FCQ_OFS_STATUS: reg_rdata <= {22'h00_0000, cache_enable, alloc_locked_reg, 5'h00, cmd_done_reg, status_reg};
        `FCQ_OFS_COAL: reg_rdata <= {16'h0000, coal_time_reg, coal_thr_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= `FCQ_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Aggregation time base
  // ----------------------------------------------------------------
  // One shared tick; a vector's first tick may come early by up to
  // one unit, which keeps the delay under the recommended maximum
  // Free-running; it never waits for a completion to start
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= 12'h000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-vector aggregation
  // ----------------------------------------------------------------
  // One aggregator per vector, all sharing the tick and the settings
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv = gv + 1) begin : g_vec
      // Strobes decoded to this vector
      wire hit;
      wire db;
      assign hit = cpl_valid && (cpl_vector == gv);
      assign db = cqhd_wr && (cqhd_vector == gv);
      fcq_coalesce_vec u_vec (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick_reg),
        .cpl_hit(hit),
        .cpl_urgent(cpl_admin | cpl_error),
        .db_hit(db),
        .coal_time(coal_time_reg),
        .coal_thr(coal_thr_reg),
        .irq_reg(irq_req[gv])
      );
    end
  endgenerate

endmodule // fcq_feature_ctrl

// ---- tb/fcq_feature_ctrl_sva.sv ----
// Port-level checker for the feature command block.
// Assumes it is bound into fcq_feature_ctrl and sees only its ports.
`timescale 1ns/100ps

module fcq_feature_sva #(
  parameter NUM_VEC = 4,
  parameter VEC_W = 2,
  parameter CACHE_POWER_SAFE = 0
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [1:0] int_mode,
  input wire cpl_valid,
  input wire [VEC_W-1:0] cpl_vector,
  input wire cpl_admin,
  input wire cpl_error,
  input wire cache_enable,
  input wire [NUM_VEC-1:0] irq_req
);
  // Shadow of the parameter word; the cache set uses its bit 0
  reg [31:0] param_reg;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      param_reg <= 32'h0000_0000;
    else if (reg_wr && reg_addr == 8'h04)
      param_reg <= reg_wdata;
  end
  wire cache_set = reg_wr && reg_addr == 8'h00 && reg_wdata[15:0] == 16'h0603;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // --------
  // Register port
  // --------
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");
  cmd_read_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == 32'h0000_0000)
    else $error("command word read not zero");
  coal_upper_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata[31:16] == 16'h0000)
    else $error("coalescing word upper half not zero");
  status_rsvd_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C |-> reg_rdata[7:3] == 5'h00 && reg_rdata[31:10] == 22'h0)
    else $error("status reserved bits set");

  // --------
  // Cache and interrupts
  // --------
  cache_set_a:
    assert property (cache_set |-> ##[1:2] cache_enable == (param_reg[0] && CACHE_POWER_SAFE == 0))
    else $error("cache enable not taken");
  safe_off_a:
    assert property (CACHE_POWER_SAFE == 0 || !cache_enable) else $error("power-safe cache enable raised");
  cache_hold_a:
    assert property (!$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(cache_enable)) else $error("cache enable moved");
  admin_now_a:
    assert property (cpl_valid && cpl_admin |=> irq_req[$past(cpl_vector)]) else $error("admin entry held back");
  error_now_a:
    assert property (cpl_valid && cpl_error |=> irq_req[$past(cpl_vector)]) else $error("error entry held back");
  mode_clear_a:
    assert property ($changed(int_mode) ##[1:2] cpl_valid |=> irq_req[$past(cpl_vector)])
    else $error("coalescing kept after mode change");

  // Main scenarios reached
  cover property (cache_set);
  cover property (cpl_valid && cpl_error);
  cover property (|irq_req && !$past(cpl_valid));
endmodule // fcq_feature_sva

bind fcq_feature_ctrl fcq_feature_sva #(.NUM_VEC(NUM_VEC), .VEC_W(VEC_W),
  .CACHE_POWER_SAFE(CACHE_POWER_SAFE)) chk (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .int_mode(int_mode), .cpl_valid(cpl_valid), .cpl_vector(cpl_vector), .cpl_admin(cpl_admin),
  .cpl_error(cpl_error), .cache_enable(cache_enable), .irq_req(irq_req));

// ---- tb/fcq_host_model.sv ----
// Host software model: register port master issuing feature commands.
// Assumes one-cycle read data and no wait states from the slave.
`timescale 1ns/100ps

module fcq_host_model (
  input wire clk_sys,
  input wire [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write; data inverted after release so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // One read; data taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Parameter, command, then result and status
  task automatic cmd(input logic [7:0] fid, input logic set, input logic [31:0] p,
                     output logic [31:0] res, output logic [31:0] st);
    wr(8'h04, p);
    wr(8'h00, {16'h0000, fid, 6'h00, set, 1'b1});
    rd(8'h08, res);
    rd(8'h0C, st);
  endtask
endmodule // fcq_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the feature command block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps

module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] int_mode = 2'h0;
  logic cpl_valid = 1'b0;
  logic [1:0] cpl_vector = 2'h0;
  logic cpl_admin = 1'b0;
  logic cpl_error = 1'b0;
  logic cqhd_wr = 1'b0;
  logic [1:0] cqhd_vector = 2'h0;
  wire [7:0] reg_addr;
  wire [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire reg_wr;
  wire reg_rd;
  wire cache_enable;
  wire cache_enable_safe;
  wire [3:0] irq_req;
  int miscompares = 0;
  int compares = 0;
  int n;
  logic [31:0] res;
  logic [31:0] st;
  logic [31:0] p;
  logic [15:0] cq_rq;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  fcq_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Unit mask of 3 so rounding up is visible
  fcq_feature_ctrl #(.ALLOC_UNIT_MASK(16'h0003)) DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_mode(int_mode),
    .cpl_valid(cpl_valid), .cpl_vector(cpl_vector), .cpl_admin(cpl_admin), .cpl_error(cpl_error),
    .cqhd_wr(cqhd_wr), .cqhd_vector(cqhd_vector), .cache_enable(cache_enable), .irq_req(irq_req));

  // Power-safe variant on the same stimulus; its enable must stay off
  fcq_feature_ctrl #(.ALLOC_UNIT_MASK(16'h0003), .CACHE_POWER_SAFE(1)) DUT_SAFE (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .int_mode(int_mode), .cpl_valid(cpl_valid), .cpl_vector(cpl_vector), .cpl_admin(cpl_admin),
    .cpl_error(cpl_error), .cqhd_wr(cqhd_wr), .cqhd_vector(cqhd_vector), .cache_enable(cache_enable_safe),
    .irq_req());

  // --------
  // Compare, stimulus and expectation helpers
  // --------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected irq at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One completion; the answer stands in the following cycle only
  task automatic cpl(input logic [1:0] v, input logic adm, input logic err, input logic [3:0] exp);
    @(posedge clk_sys);
    cpl_valid <= 1'b1;
    cpl_vector <= v;
    cpl_admin <= adm;
    cpl_error <= err;
    @(posedge clk_sys);
    cpl_valid <= 1'b0;
    cpl_vector <= ~v;
    #1;
    chk_irq(irq_req, exp);
  endtask

  task automatic db(input logic [1:0] v);
    @(posedge clk_sys);
    cqhd_wr <= 1'b1;
    cqhd_vector <= v;
    @(posedge clk_sys);
    cqhd_wr <= 1'b0;
  endtask

  // Round up to the unit, then clip to the supply
  function automatic logic [15:0] exp_alloc(input logic [15:0] r);
    logic [15:0] u;
    u = r | 16'h0003;
    exp_alloc = (u > 16'h003F) ? 16'h003F : u;
  endfunction

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 10k cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report;
  end

  // --------
  // Main sequence
  // --------
  initial begin
    void'($urandom(3));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    host.rd(8'h10, res);
    chk_word(res, 32'h0000_0000);
    $display("test reset_values done");
    // Cache on and off, reserved bits filled with noise
    for (n = 0; n < 4; n++) begin
      p = $urandom;
      p[0] = n[0];
      host.cmd(8'h06, 1'b1, p, res, st);
      chk_word(res, {31'h0, p[0]});
      chk_word({31'h0, cache_enable}, {31'h0, p[0]});
      chk_word({31'h0, cache_enable_safe}, 32'h0000_0000);
      host.cmd(8'h06, 1'b0, ~p, res, st);
      chk_word(res, {31'h0, p[0]});
    end
    $display("test cache done");
    // Queue counts, set only before any I/O traffic, at least one each
    host.cmd(8'h07, 1'b0, 32'h0000_0000, res, st);
    chk_word(res, 32'h003F_003F);
    host.cmd(8'h07, 1'b1, 32'hFFFF_0001, res, st);
    chk_word({res[31:2], st[1:0]}, {30'h000F_C00F, 2'h1});
    cq_rq = 16'($urandom_range(127));
    host.cmd(8'h07, 1'b1, {cq_rq, 16'h0000}, res, st);
    chk_word(res, {exp_alloc(cq_rq), 16'h0003});
    host.cmd(8'h07, 1'b1, 32'h0001_0001, res, st);
    chk_word(res, {exp_alloc(cq_rq), 16'h0003});
    host.cmd(8'h07, 1'b0, 32'h0000_0000, res, st);
    chk_word(res, {exp_alloc(cq_rq), 16'h0003});
    host.cmd(8'h05, 1'b0, 32'h0000_0000, res, st);
    chk_word({res[31:2], st[1:0]}, {30'h0, 2'h2});
    $display("test queues done");
    // Coalescing read back, then zero fields disable it
    p = $urandom;
    host.cmd(8'h08, 1'b1, p, res, st);
    chk_word(res, {16'h0000, p[15:0]});
    host.rd(8'h10, res);
    chk_word(res, {16'h0000, p[15:0]});
    host.cmd(8'h08, 1'b0, ~p, res, st);
    chk_word(res, {16'h0000, p[15:0]});
    host.cmd(8'h08, 1'b1, 32'h0000_C800, res, st);
    cpl(2'h1, 1'b0, 1'b0, 4'h2);
    host.cmd(8'h08, 1'b1, 32'h0000_00C8, res, st);
    cpl(2'h1, 1'b0, 1'b0, 4'h2);
    // Threshold of three entries, doorbell restarts the count
    host.cmd(8'h08, 1'b1, 32'h0000_C802, res, st);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    cpl(2'h1, 1'b0, 1'b0, 4'h2);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    db(2'h1);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    cpl(2'h1, 1'b0, 1'b0, 4'h2);
    cpl(2'h2, 1'b1, 1'b0, 4'h4);
    cpl(2'h3, 1'b0, 1'b1, 4'h8);
    // Time limit of two steps: fires one to two units later
    host.cmd(8'h08, 1'b1, 32'h0000_02C8, res, st);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    n = 0;
    while (irq_req[1] !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_word({31'h0, n > 1990 && n < 4010}, 32'h0000_0001);
    $display("test coalescing done");
    // Mode change drops coalescing; host then sends it again
    host.cmd(8'h08, 1'b1, 32'h0000_C802, res, st);
    @(posedge clk_sys);
    int_mode <= 2'h2;
    cpl(2'h1, 1'b0, 1'b0, 4'h2);
    host.rd(8'h10, res);
    chk_word(res, 32'h0000_0000);
    host.cmd(8'h08, 1'b1, 32'h0000_C802, res, st);
    cpl(2'h1, 1'b0, 1'b0, 4'h0);
    // Mid-run reset frees the allocation and clears the cache
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    host.cmd(8'h07, 1'b0, 32'h0000_0000, res, st);
    chk_word(res, 32'h003F_003F);
    chk_word({31'h0, cache_enable}, 32'h0000_0000);
    $display("test mode_and_reset done");
    final_report;
  end
endmodule // tb_top
